// ===== design/svmon_cfg.svh
`ifndef SVMON_CFG_SVH
`define SVMON_CFG_SVH

// register byte offsets
`define SVMON_OFF_STICKY      8'h00
`define SVMON_OFF_LIVE        8'h04
`define SVMON_OFF_RD_MASK     8'h08
`define SVMON_OFF_INT_EN      8'h0c
`define SVMON_OFF_RST_SEL     8'h10
`define SVMON_OFF_THRESH      8'h14
`define SVMON_OFF_IRQ_STAT    8'h18
`define SVMON_OFF_IRQ_MASK    8'h1c

// monitor bit positions, same in sticky, live and enable registers
`define SVMON_BIT_DIG_LOW     0
`define SVMON_BIT_ANA_LOW     1
`define SVMON_BIT_ANA_HIGH    2

// reset select field
`define SVMON_RSEL_DIG_BIT    6
`define SVMON_RSEL_ANA_BIT    7

// threshold field
`define SVMON_THR_DIG_LSB     0
`define SVMON_THR_ANA_LSB     4

// reset values
`define SVMON_RST_INT_EN      3'h0
`define SVMON_RST_RST_SEL     2'h0
`define SVMON_RST_THRESH      4'h0
`define SVMON_RST_RD_MASK     3'h7
`define SVMON_RST_FLAGS       3'h0

// fixed high detector trip level and low monitor trip code step, millivolts
`define SVMON_HIGH_TRIP_MV    5750
`define SVMON_LOW_STEP_MV     250

`endif

// ===== design/svmon_pkg.sv
package svmon_pkg;
  typedef logic [2:0]  svmon_flags_t;
  typedef logic [3:0]  svmon_thresh_t;
  typedef logic [31:0] svmon_word_t;
  typedef logic [7:0]  svmon_addr_t;
  typedef enum logic [1:0] {
    SVMON_ACC_IDLE,
    SVMON_ACC_READ,
    SVMON_ACC_WRITE
  } svmon_acc_t;
endpackage

// ===== design/svmon_sticky_bit.sv
`timescale 1ns/1ps
`default_nettype none
module svmon_sticky_bit (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic set_in,
  input  wire logic clear_in,
  input  wire logic flush_in,
  output logic      flag_out
);
  logic flag_reg;
  logic flag_next;

  // flush beats set: a voltage reset leaves nothing behind
  always_comb begin
    flag_next = flag_reg;
    if (flush_in) begin
      flag_next = 1'b0;
    end else if (set_in) begin
      flag_next = 1'b1;
    end else if (clear_in) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;
endmodule
`default_nettype wire

// ===== design/svmon_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "svmon_cfg.svh"
module svmon_irq (
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire svmon_pkg::svmon_flags_t event_in,
  input  wire logic                  wr_stat_in,
  input  wire logic                  wr_mask_in,
  input  wire svmon_pkg::svmon_flags_t wdata_in,
  output svmon_pkg::svmon_flags_t    status_out,
  output svmon_pkg::svmon_flags_t    mask_out,
  output logic                       irq_out
);
  import svmon_pkg::*;
  svmon_flags_t stat_reg;
  svmon_flags_t mask_reg;

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stat_reg <= `SVMON_RST_FLAGS;
    end else begin
      stat_reg <= (stat_reg & ~(wr_stat_in ? wdata_in : 3'h0)) | event_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_reg <= `SVMON_RST_FLAGS;
    end else if (wr_mask_in) begin
      mask_reg <= wdata_in;
    end
  end

  assign status_out = stat_reg;
  assign mask_out   = mask_reg;
  assign irq_out    = |(stat_reg & mask_reg);
endmodule
`default_nettype wire

// ===== design/svmon_ctrl.sv
// Summary of operation
// - A voltage reset is a one-cycle pulse that returns monitor enables and reset selects to off.
// - Re-enabling a reset while the supply is still out of range fires the reset again.
// - Any voltage reset clears both the sticky and the live status registers.
// - Enabling the high monitor turns its output on at a fixed 5.75 V trip level.
// - A sticky flag sets while its supply is out of range and holds until read-cleared or reset.
// - A sticky read returns and clears only the bits in the read mask, others read as zero.
// - Sticky flags sit at bit 0 digital low, bit 1 analog low, bit 2 analog high.
// - A live bit follows its detector output with no latching.
// - Live bits use the same placement as the sticky flags.
// - Each low monitor takes a 4-bit trip code, 250 mV per step from 1.70 V.
// - Three enables gate events; two selects turn a low event into a reset instead.
// - The combined event output is a level, high while any routed enabled detector fires.
`timescale 1ns/1ps
`default_nettype none
`include "svmon_cfg.svh"
module svmon_ctrl (
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  wb_cyc_in,
  input  wire logic                  wb_stb_in,
  input  wire logic                  wb_we_in,
  input  wire svmon_pkg::svmon_addr_t wb_adr_in,
  input  wire logic [3:0]            wb_sel_in,
  input  wire svmon_pkg::svmon_word_t wb_dat_in,
  output svmon_pkg::svmon_word_t     wb_dat_out,
  output logic                       wb_ack_out,
  input  wire logic                  dig_low_cmp_in,
  input  wire logic                  ana_low_cmp_in,
  input  wire logic                  ana_high_cmp_in,
  output svmon_pkg::svmon_flags_t    monitor_enable_out,
  output svmon_pkg::svmon_thresh_t   dig_thresh_out,
  output svmon_pkg::svmon_thresh_t   ana_thresh_out,
  output logic                       voltage_reset_out,
  output logic                       voltage_event_out,
  output logic                       irq_out
);
  import svmon_pkg::*;

  function automatic logic addr_hit(input svmon_addr_t a, input svmon_addr_t off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction

  svmon_flags_t  int_en_reg;
  logic [1:0]    rst_sel_reg;
  svmon_thresh_t dig_thr_reg;
  svmon_thresh_t ana_thr_reg;
  svmon_flags_t  rd_mask_reg;
  svmon_flags_t  live_reg;
  svmon_flags_t  sticky;
  svmon_flags_t  det;
  svmon_flags_t  cmp;
  svmon_flags_t  clr;
  svmon_flags_t  irq_event;
  svmon_flags_t  irq_stat;
  svmon_flags_t  irq_mask;
  svmon_flags_t  routed;
  logic          trig;
  logic          vrst_reg;
  logic          ack_reg;
  svmon_word_t   dat_reg;
  svmon_word_t   rd_data;
  svmon_acc_t    acc;
  logic          wr_lane0;
  logic          rd_sticky;

  // bus access classification, one cycle per request
  always_comb begin
    acc = SVMON_ACC_IDLE;
    if (wb_cyc_in && wb_stb_in && !ack_reg) begin
      acc = wb_we_in ? SVMON_ACC_WRITE : SVMON_ACC_READ;
    end
  end

  assign wr_lane0  = (acc == SVMON_ACC_WRITE) && wb_sel_in[0];
  assign rd_sticky = (acc == SVMON_ACC_READ) && addr_hit(wb_adr_in, `SVMON_OFF_STICKY);

  // detector outputs only count while their monitor is enabled
  assign cmp[`SVMON_BIT_DIG_LOW]  = dig_low_cmp_in;
  assign cmp[`SVMON_BIT_ANA_LOW]  = ana_low_cmp_in;
  assign cmp[`SVMON_BIT_ANA_HIGH] = ana_high_cmp_in;
  assign det = cmp & int_en_reg;

  // the high detector has no reset option, it only ever interrupts
  assign routed = int_en_reg & ~{1'b0, rst_sel_reg};

  // reset fires whenever an enabled low monitor with reset selected trips
  assign trig = |(det[1:0] & rst_sel_reg);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vrst_reg <= 1'b0;
    end else begin
      vrst_reg <= trig;
    end
  end

  // enable register; a voltage reset beats a software write
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_en_reg <= `SVMON_RST_INT_EN;
    end else if (trig) begin
      int_en_reg <= `SVMON_RST_INT_EN;
    end else if (wr_lane0 && addr_hit(wb_adr_in, `SVMON_OFF_INT_EN)) begin
      int_en_reg <= wb_dat_in[2:0];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sel_reg <= `SVMON_RST_RST_SEL;
    end else if (trig) begin
      rst_sel_reg <= `SVMON_RST_RST_SEL;
    end else if (wr_lane0 && addr_hit(wb_adr_in, `SVMON_OFF_RST_SEL)) begin
      rst_sel_reg <= {wb_dat_in[`SVMON_RSEL_ANA_BIT], wb_dat_in[`SVMON_RSEL_DIG_BIT]};
    end
  end

  // trip codes survive a voltage reset; enables, selects, live and sticky bits revert
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dig_thr_reg <= `SVMON_RST_THRESH;
      ana_thr_reg <= `SVMON_RST_THRESH;
    end else if (wr_lane0 && addr_hit(wb_adr_in, `SVMON_OFF_THRESH)) begin
      dig_thr_reg <= wb_dat_in[`SVMON_THR_DIG_LSB +: 4];
      ana_thr_reg <= wb_dat_in[`SVMON_THR_ANA_LSB +: 4];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_mask_reg <= `SVMON_RST_RD_MASK;
    end else if (wr_lane0 && addr_hit(wb_adr_in, `SVMON_OFF_RD_MASK)) begin
      rd_mask_reg <= wb_dat_in[2:0];
    end
  end

  // live copy of the gated detectors, one register stage
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      live_reg <= `SVMON_RST_FLAGS;
    end else if (trig) begin
      live_reg <= `SVMON_RST_FLAGS;
    end else begin
      live_reg <= det;
    end
  end

  assign clr = rd_sticky ? rd_mask_reg : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sticky
      svmon_sticky_bit u_flag (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .set_in     (det[gi]),
        .clear_in   (clr[gi]),
        .flush_in   (trig),
        .flag_out   (sticky[gi])
      );
    end
  endgenerate

  // rising edges of routed detectors feed the interrupt status
  assign irq_event = det & ~live_reg & routed & {3{!trig}};

  svmon_irq u_irq (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .event_in   (irq_event),
    .wr_stat_in (wr_lane0 && addr_hit(wb_adr_in, `SVMON_OFF_IRQ_STAT)),
    .wr_mask_in (wr_lane0 && addr_hit(wb_adr_in, `SVMON_OFF_IRQ_MASK)),
    .wdata_in   (wb_dat_in[2:0]),
    .status_out (irq_stat),
    .mask_out   (irq_mask),
    .irq_out    (irq_out)
  );

  // read mux; unmapped addresses read zero and still acknowledge
  always_comb begin
    rd_data = 32'h0000_0000;
    if (addr_hit(wb_adr_in, `SVMON_OFF_STICKY)) begin
      rd_data[2:0] = sticky & rd_mask_reg;
    end else if (addr_hit(wb_adr_in, `SVMON_OFF_LIVE)) begin
      rd_data[2:0] = live_reg;
    end else if (addr_hit(wb_adr_in, `SVMON_OFF_RD_MASK)) begin
      rd_data[2:0] = rd_mask_reg;
    end else if (addr_hit(wb_adr_in, `SVMON_OFF_INT_EN)) begin
      rd_data[2:0] = int_en_reg;
    end else if (addr_hit(wb_adr_in, `SVMON_OFF_RST_SEL)) begin
      rd_data[`SVMON_RSEL_DIG_BIT] = rst_sel_reg[0];
      rd_data[`SVMON_RSEL_ANA_BIT] = rst_sel_reg[1];
    end else if (addr_hit(wb_adr_in, `SVMON_OFF_THRESH)) begin
      rd_data[7:0] = {ana_thr_reg, dig_thr_reg};
    end else if (addr_hit(wb_adr_in, `SVMON_OFF_IRQ_STAT)) begin
      rd_data[2:0] = irq_stat;
    end else if (addr_hit(wb_adr_in, `SVMON_OFF_IRQ_MASK)) begin
      rd_data[2:0] = irq_mask;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (acc != SVMON_ACC_IDLE);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dat_reg <= 32'h0000_0000;
    end else if (acc == SVMON_ACC_READ) begin
      dat_reg <= rd_data;
    end
  end

  assign wb_dat_out         = dat_reg;
  assign wb_ack_out         = ack_reg;
  assign monitor_enable_out = int_en_reg;
  assign dig_thresh_out     = dig_thr_reg;
  assign ana_thresh_out     = ana_thr_reg;
  assign voltage_reset_out  = vrst_reg;
  assign voltage_event_out  = |(live_reg & routed);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  vrst_restore_a: assert property (
    vrst_reg |-> (int_en_reg == 3'h0) && (rst_sel_reg == 2'h0)
  ) else $error("controls not restored on voltage reset");

  vrst_pulse_a: assert property (
    vrst_reg |=> !vrst_reg
  ) else $error("voltage reset longer than one cycle");

  vrst_repeat_a: assert property (
    (int_en_reg[0] && rst_sel_reg[0] && dig_low_cmp_in) |=> vrst_reg
  ) else $error("digital low reset did not fire");

  vrst_clear_a: assert property (
    vrst_reg |-> (sticky == 3'h0) && (live_reg == 3'h0)
  ) else $error("status survived voltage reset");

  sticky_set_a: assert property (
    (det[2] && !trig) |=> sticky[2]
  ) else $error("high flag not set");

  sticky_hold_a: assert property (
    (sticky[2] && !trig && !clr[2]) |=> sticky[2]
  ) else $error("high flag not held");

  mask_read_a: assert property (
    (rd_sticky && !trig && !det[0]) |=> (wb_dat_out[0] == $past(sticky[0] & rd_mask_reg[0]))
      && (sticky[0] == ($past(sticky[0]) && !$past(rd_mask_reg[0])))
  ) else $error("masked sticky read wrong");

  unmasked_keep_a: assert property (
    (rd_sticky && !trig) |=> ((($past(sticky) & ~$past(rd_mask_reg)) & ~sticky) == 3'h0)
  ) else $error("unmasked sticky bit cleared");

  live_track_a: assert property (
    (!trig && ana_low_cmp_in && int_en_reg[1]) |=> live_reg[1] && sticky[1]
  ) else $error("analog low live bit missed");

  set_wins_a: assert property (
    (rd_sticky && rd_mask_reg[1] && det[1] && !trig) |=> sticky[1]
  ) else $error("event lost to clearing read");

  event_level_a: assert property (
    (ana_high_cmp_in && int_en_reg[2] && !trig) |=> voltage_event_out || !int_en_reg[2]
  ) else $error("event output low during high event");

  irq_route_a: assert property (
    (irq_event != 3'h0) |=> ((irq_stat & $past(irq_event)) == $past(irq_event))
  ) else $error("routed event missing from interrupt status");

  ack_once_a: assert property (
    wb_ack_out |=> !wb_ack_out
  ) else $error("ack held two cycles");

  // a voltage reset cycle is left out where it flushes the flags
  live_clear_a: assert property (
    (!ana_high_cmp_in && !trig) |=> !live_reg[2]
  ) else $error("live bit latched");

  live_place_a: assert property (
    !trig |=> (live_reg == $past({ana_high_cmp_in, ana_low_cmp_in, dig_low_cmp_in} & int_en_reg))
  ) else $error("live bit placement wrong");

  sticky_place_a: assert property (
    (dig_low_cmp_in && int_en_reg[0] && !trig) |=> sticky[0]
  ) else $error("digital low flag not at bit 0");

  trip_code_a: assert property (
    (wr_lane0 && addr_hit(wb_adr_in, `SVMON_OFF_THRESH))
      |=> (dig_thresh_out == $past(wb_dat_in[3:0])) && (ana_thresh_out == $past(wb_dat_in[7:4]))
  ) else $error("trip codes not taken");

  route_sel_a: assert property (
    irq_event[0] |-> !rst_sel_reg[0]
  ) else $error("reset-routed event interrupted");

  vrst_cause_a: assert property (
    vrst_reg |-> $past(|({ana_low_cmp_in, dig_low_cmp_in} & int_en_reg[1:0] & rst_sel_reg))
  ) else $error("voltage reset without a routed low event");

  event_gone_a: assert property (
    (int_en_reg == 3'h0) |=> !voltage_event_out
  ) else $error("event output high with monitors off");

  disable_high_a: assert property (
    (wr_lane0 && addr_hit(wb_adr_in, `SVMON_OFF_INT_EN) && !wb_dat_in[2]) |=> ##1 !live_reg[2]
  ) else $error("high monitor still live after disable");

  unmasked_zero_a: assert property (
    rd_sticky |=> ((wb_dat_out[2:0] & ~$past(rd_mask_reg)) == 3'h0)
  ) else $error("unselected sticky bit returned");

  ack_timing_a: assert property (
    (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out
  ) else $error("request not acknowledged next cycle");

  upper_zero_a: assert property (
    wb_ack_out |-> (wb_dat_out[31:8] == 24'h0)
  ) else $error("upper read bits not zero");

  sel_gate_a: assert property (
    (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && !wb_sel_in[0] && !trig)
      |=> (int_en_reg == $past(int_en_reg))
  ) else $error("write without lane 0 landed");

  dat_hold_a: assert property (
    !(wb_cyc_in && wb_stb_in && !wb_we_in) |=> $stable(wb_dat_out)
  ) else $error("read data changed without a read");

  vrst_seen_c: cover property (vrst_reg ##1 !vrst_reg);
  sticky_read_c: cover property (rd_sticky && (sticky != 3'h0));
  race_c: cover property (rd_sticky && (det & rd_mask_reg) != 3'h0);
  irq_c: cover property ($rose(irq_out));
  repeat_c: cover property (vrst_reg ##[2:60] vrst_reg);
endmodule
`default_nettype wire

// ===== sim/supply_monitor_status_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "svmon_cfg.svh"
module supply_monitor_status_ctrl_tb;
  import svmon_pkg::*;
  typedef struct packed {
    logic        we;
    svmon_addr_t adr;
    logic [3:0]  sel;
    svmon_word_t wdat;
    svmon_word_t exp;
  } smsc_row_t;
  logic          clk_in;
  logic          reset_n_in;
  logic          wb_cyc_in;
  logic          wb_stb_in;
  logic          wb_we_in;
  svmon_addr_t   wb_adr_in;
  logic [3:0]    wb_sel_in;
  svmon_word_t   wb_dat_in;
  svmon_word_t   wb_dat_out;
  svmon_word_t   rd;
  logic          wb_ack_out;
  logic [2:0]    cmp;
  svmon_flags_t  monitor_enable_out;
  svmon_thresh_t dig_thresh_out;
  svmon_thresh_t ana_thresh_out;
  logic          voltage_reset_out;
  logic          voltage_event_out;
  logic          irq_out;
  int            n_fail = 0;
  int            total_checks = 0;
  int            n_cycles = 0;
  int            n_vrst = 0;
  // defaults first, then write and read back; sel[0] low must not write
  localparam smsc_row_t ROWS [0:17] = '{
    '{1'b0, `SVMON_OFF_STICKY, 4'hf, 32'h0, 32'h0},
    '{1'b0, `SVMON_OFF_LIVE, 4'hf, 32'h0, 32'h0},
    '{1'b0, `SVMON_OFF_RD_MASK, 4'hf, 32'h0, 32'h7},
    '{1'b0, `SVMON_OFF_INT_EN, 4'hf, 32'h0, 32'h0},
    '{1'b0, `SVMON_OFF_RST_SEL, 4'hf, 32'h0, 32'h0},
    '{1'b0, `SVMON_OFF_THRESH, 4'hf, 32'h0, 32'h0},
    '{1'b0, `SVMON_OFF_IRQ_STAT, 4'hf, 32'h0, 32'h0},
    '{1'b0, `SVMON_OFF_IRQ_MASK, 4'hf, 32'h0, 32'h0},
    '{1'b1, `SVMON_OFF_THRESH, 4'hf, 32'ha5, 32'ha5},
    '{1'b1, `SVMON_OFF_RD_MASK, 4'hf, 32'h5, 32'h5},
    '{1'b1, `SVMON_OFF_RD_MASK, 4'hf, 32'h7, 32'h7},
    '{1'b1, `SVMON_OFF_IRQ_MASK, 4'hf, 32'h7, 32'h7},
    '{1'b1, `SVMON_OFF_IRQ_MASK, 4'he, 32'h0, 32'h7},
    '{1'b1, `SVMON_OFF_RST_SEL, 4'hf, 32'hc0, 32'hc0},
    '{1'b1, `SVMON_OFF_RST_SEL, 4'hf, 32'h0, 32'h0},
    '{1'b1, `SVMON_OFF_INT_EN, 4'hf, 32'h7, 32'h7},
    '{1'b1, `SVMON_OFF_LIVE, 4'hf, 32'hff, 32'h0},
    '{1'b1, 8'h20, 4'hf, 32'hff, 32'h0}
  };

  svmon_ctrl dut (
    .clk_in             (clk_in),
    .reset_n_in         (reset_n_in),
    .wb_cyc_in          (wb_cyc_in),
    .wb_stb_in          (wb_stb_in),
    .wb_we_in           (wb_we_in),
    .wb_adr_in          (wb_adr_in),
    .wb_sel_in          (wb_sel_in),
    .wb_dat_in          (wb_dat_in),
    .wb_dat_out         (wb_dat_out),
    .wb_ack_out         (wb_ack_out),
    .dig_low_cmp_in     (cmp[0]),
    .ana_low_cmp_in     (cmp[1]),
    .ana_high_cmp_in    (cmp[2]),
    .monitor_enable_out (monitor_enable_out),
    .dig_thresh_out     (dig_thresh_out),
    .ana_thresh_out     (ana_thresh_out),
    .voltage_reset_out  (voltage_reset_out),
    .voltage_event_out  (voltage_event_out),
    .irq_out            (irq_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles; this only cuts a hang
  always @(posedge clk_in) begin
    n_cycles++;
    if (n_cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // a pulse longer than one cycle counts once for every cycle it stays high
  always @(posedge clk_in) begin
    if (voltage_reset_out === 1'b1) n_vrst++;
  end

  task automatic check_reg(input string what, input svmon_word_t exp, input svmon_word_t got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_pin(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic bus(input logic we, input svmon_addr_t adr, input logic [3:0] sel,
                     input svmon_word_t dat);
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_sel_in <= sel;
    wb_dat_in <= dat;
    @(posedge clk_in);
    while (wb_ack_out !== 1'b1) @(posedge clk_in);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask

  task automatic wr(input svmon_addr_t adr, input svmon_word_t dat);
    bus(1'b1, adr, 4'hf, dat);
  endtask

  task automatic rchk(input string what, input svmon_addr_t adr, input svmon_word_t exp);
    bus(1'b0, adr, 4'hf, 32'h0);
    check_reg(what, exp, rd);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  initial begin
    reset_n_in = 1'b0;
    wb_cyc_in  = 1'b0;
    wb_stb_in  = 1'b0;
    wb_we_in   = 1'b0;
    wb_adr_in  = 8'h00;
    wb_sel_in  = 4'h0;
    wb_dat_in  = 32'h0;
    cmp        = 3'h0;
    cycles(16);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 18; i++) begin
      if (ROWS[i].we) bus(1'b1, ROWS[i].adr, ROWS[i].sel, ROWS[i].wdat);
      rchk("register row", ROWS[i].adr, ROWS[i].exp);
    end
    @(negedge clk_in);
    check_reg("trip codes", 32'ha5, {24'h0, ana_thresh_out, dig_thresh_out});
    check_reg("monitor enables", 32'h7, {29'h0, monitor_enable_out});
    // one detector at a time shows where each bit sits
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      cmp <= 3'h1 << i;
      cycles(3);
      rchk("live high", `SVMON_OFF_LIVE, 32'h1 << i);
      check_pin("event level", 1'b1, voltage_event_out);
      check_pin("irq raised", 1'b1, irq_out);
      cmp <= 3'h0;
      cycles(3);
      rchk("live low", `SVMON_OFF_LIVE, 32'h0);
      check_pin("event gone", 1'b0, voltage_event_out);
      rchk("sticky set", `SVMON_OFF_STICKY, 32'h1 << i);
      rchk("sticky cleared", `SVMON_OFF_STICKY, 32'h0);
      rchk("irq status", `SVMON_OFF_IRQ_STAT, 32'h1 << i);
      wr(`SVMON_OFF_IRQ_STAT, 32'h1 << i);
      @(negedge clk_in);
      check_pin("irq cleared", 1'b0, irq_out);
    end
    wr(`SVMON_OFF_IRQ_MASK, 32'h0);
    cmp <= 3'h2;
    cycles(2);
    cmp <= 3'h0;
    cycles(2);
    @(negedge clk_in);
    check_pin("irq masked", 1'b0, irq_out);
    wr(`SVMON_OFF_IRQ_MASK, 32'h7);
    @(negedge clk_in);
    check_pin("irq unmasked", 1'b1, irq_out);
    wr(`SVMON_OFF_IRQ_STAT, 32'h7);
    @(negedge clk_in);
    check_pin("irq w1c", 1'b0, irq_out);
    rchk("sticky after mask test", `SVMON_OFF_STICKY, 32'h2);
    cmp <= 3'h7;
    cycles(2);
    cmp <= 3'h0;
    wr(`SVMON_OFF_RD_MASK, 32'h5);
    rchk("masked read", `SVMON_OFF_STICKY, 32'h5);
    rchk("masked reread", `SVMON_OFF_STICKY, 32'h0);
    wr(`SVMON_OFF_RD_MASK, 32'h7);
    rchk("unselected kept", `SVMON_OFF_STICKY, 32'h2);
    // detector still active while the clearing read lands
    cmp <= 3'h4;
    cycles(3);
    rchk("set during read", `SVMON_OFF_STICKY, 32'h4);
    rchk("set survives read", `SVMON_OFF_STICKY, 32'h4);
    cmp <= 3'h0;
    cycles(2);
    rchk("sticky held", `SVMON_OFF_STICKY, 32'h4);
    rchk("sticky drained", `SVMON_OFF_STICKY, 32'h0);
    wr(`SVMON_OFF_IRQ_STAT, 32'h7);
    wr(`SVMON_OFF_INT_EN, 32'h0);
    cmp <= 3'h7;
    cycles(3);
    rchk("disabled live", `SVMON_OFF_LIVE, 32'h0);
    rchk("disabled sticky", `SVMON_OFF_STICKY, 32'h0);
    check_pin("disabled event", 1'b0, voltage_event_out);
    cmp <= 3'h4;
    wr(`SVMON_OFF_INT_EN, 32'h4);
    cycles(3);
    rchk("high live", `SVMON_OFF_LIVE, 32'h4);
    wr(`SVMON_OFF_RST_SEL, 32'h40);
    wr(`SVMON_OFF_INT_EN, 32'h5);
    cmp <= 3'h5;
    cycles(4);
    check_reg("reset pulses", 32'd1, n_vrst);
    check_reg("enables off", 32'h0, {29'h0, monitor_enable_out});
    rchk("enable default", `SVMON_OFF_INT_EN, 32'h0);
    rchk("select default", `SVMON_OFF_RST_SEL, 32'h0);
    rchk("sticky wiped", `SVMON_OFF_STICKY, 32'h0);
    rchk("live wiped", `SVMON_OFF_LIVE, 32'h0);
    rchk("trip kept", `SVMON_OFF_THRESH, 32'ha5);
    wr(`SVMON_OFF_RST_SEL, 32'h40);
    wr(`SVMON_OFF_INT_EN, 32'h1);
    cycles(8);
    check_reg("reset repeats once", 32'd2, n_vrst);
    cmp <= 3'h0;
    reset_n_in <= 1'b0;
    cycles(2);
    @(negedge clk_in);
    check_pin("irq in reset", 1'b0, irq_out);
    check_reg("enables in reset", 32'h0, {29'h0, monitor_enable_out});
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    rchk("trip after reset", `SVMON_OFF_THRESH, 32'h0);
    rchk("mask after reset", `SVMON_OFF_RD_MASK, 32'h7);
    conclude();
  end
endmodule
`default_nettype wire
